// ===== rtl/ssf_initiator.sv
`timescale 1ns/10ps
`default_nettype none
module ssf_initiator (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // link
  ssf_link_if.initiator    link,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  logic [15:0] grant;      // bytes still allowed by current grant
  logic [31:0] offset;
  logic [15:0] burst;
  logic        aborted;
  logic        wrPend;
  logic [31:0] wrWord;
  logic [7:0]  rspInfo;    // {valid, dropped, dp[1:0], 4'h0}
  logic [7:0]  rspStat;
  logic [31:0] rdWord;
  logic [3:0]  rspIdx;
  logic        access;
  assign access = psel && penable && pready;

  //========================================================================
  // apb answers in one wait state; unmapped reads give zero, error flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        case (paddr)
          ssf_pkg::SSF_A_STAT: prdata <= {29'h0, aborted, wrPend,
                                          grant != 16'h0};
          ssf_pkg::SSF_A_OFFSET: prdata <= offset;
          ssf_pkg::SSF_A_RSP: prdata <= {16'h0, rspInfo, rspStat};
          ssf_pkg::SSF_A_RDATA: prdata <= rdWord;
          ssf_pkg::SSF_A_CTRL, ssf_pkg::SSF_A_GRANT,
          ssf_pkg::SSF_A_WDATA, ssf_pkg::SSF_A_BURST: prdata <= 32'h0;
          default: begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  //========================================================================
  // write path: send one-word frames while a grant remains
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grant <= 16'h0;
      offset <= ssf_pkg::SSF_RST_OFFSET;
      burst <= 16'h0;
      aborted <= 1'b0;
      wrPend <= 1'b0;
      wrWord <= 32'h0;
      link.iValid <= 1'b0;
      link.iSof <= 1'b0;
      link.iEof <= 1'b0;
      link.iKind <= 2'h0;
      link.iData <= 32'h0;
      link.iOffset <= 32'h0;
      link.iFill <= ssf_pkg::SSF_RST_FILL;
      link.iFirstBurst <= 1'b0;
    end else begin
      link.iValid <= 1'b0;
      link.iSof <= 1'b0;
      link.iEof <= 1'b0;
      if (access && pwrite && paddr == ssf_pkg::SSF_A_BURST)
        burst <= pwdata[15:0];
      if (access && pwrite && paddr == ssf_pkg::SSF_A_CTRL) begin
        if (pwdata[0]) begin // new command frame
          link.iValid <= 1'b1;
          link.iSof <= 1'b1;
          link.iEof <= 1'b1;
          link.iKind <= 2'h0;
          link.iFirstBurst <= burst != 16'h0;
          grant <= burst; // see RULE3
          offset <= 32'h0; // see RULE11
          aborted <= 1'b0;
        end else if (pwdata[1]) begin // abort task frame
          link.iValid <= 1'b1;
          link.iSof <= 1'b1;
          link.iEof <= 1'b1;
          link.iKind <= 2'h2;
          grant <= 16'h0; // see RULE8
          aborted <= 1'b1;
        end
      end else if (link.tValid && link.tKind == 2'h2 && !aborted) begin
        grant <= link.tData[15:0]; // see RULE3
        offset <= link.tOffset == 32'h0 ? offset : link.tOffset;
      end else if (wrPend && grant != 16'h0 && !aborted) begin
        // each frame stays inside one grant
        link.iValid <= 1'b1; // see RULE5
        link.iSof <= 1'b1;
        link.iEof <= 1'b1;
        link.iKind <= 2'h1;
        link.iData <= wrWord;
        link.iOffset <= {offset[31:2], 2'h0}; // see RULE9
        wrPend <= 1'b0;
        if (grant <= 16'h4) begin
          link.iFill <= 2'(3'h4 - 3'(grant)); // see RULE6
          offset <= offset + 32'(grant); // see RULE11
          grant <= 16'h0;
        end else begin
          link.iFill <= 2'h0;
          offset <= offset + 32'h4;
          grant <= grant - 16'h4;
        end
      end
      // a word written while the old one leaves must stay pending
      if (access && pwrite && paddr == ssf_pkg::SSF_A_WDATA) begin
        wrWord <= pwdata;
        wrPend <= 1'b1;
      end
    end
  end

  //========================================================================
  // receive: read data capture and response decode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rspInfo <= 8'h0;
      rspStat <= 8'h0;
      rdWord <= 32'h0;
      rspIdx <= 4'h0;
    end else if (link.tValid) begin
      if (link.tKind == 2'h1)
        rdWord <= link.tData;
      if (link.tKind == 2'h3) begin
        rspIdx <= link.tEof ? 4'h0 : (link.tSof ? 4'h1 : rspIdx + 4'h1);
        if (!link.tSof && rspIdx == 4'h2) begin
          if (link.tData[9:8] == ssf_pkg::SSF_DP_RSVD)
            rspInfo <= 8'h40 | {2'h0, link.tData[9:8], 4'h0}; // see RULE18
          else begin
            rspInfo <= 8'h80 | {2'h0, link.tData[9:8], 4'h0}; // see RULE14
            rspStat <= link.tData[7:0];
          end
        end
      end
    end
  end
endmodule : ssf_initiator
`default_nettype wire

// ===== rtl/ssf_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// frame channel: one word per valid beat, sof/eof mark frame bounds
interface ssf_link_if;
  // initiator to target
  logic        iValid;
  logic        iSof;
  logic        iEof;
  logic [1:0]  iKind;    // 0 command, 1 write data, 2 task
  logic [31:0] iData;
  logic [31:0] iOffset;
  logic [1:0]  iFill;
  logic        iFirstBurst;
  // target to initiator
  logic        tValid;
  logic        tSof;
  logic        tEof;
  logic [1:0]  tKind;    // 1 read data, 2 transfer ready, 3 response
  logic [31:0] tData;
  logic [31:0] tOffset;
  logic [1:0]  tFill;
  modport target (input iValid, iSof, iEof, iKind, iData, iOffset, iFill,
    iFirstBurst, output tValid, tSof, tEof, tKind, tData, tOffset, tFill);
  modport initiator (output iValid, iSof, iEof, iKind, iData, iOffset,
    iFill, iFirstBurst, input tValid, tSof, tEof, tKind, tData, tOffset,
    tFill);
endinterface : ssf_link_if
`default_nettype wire

// ===== rtl/ssf_pkg.sv
//==========================================================================
// Notes on behaviour
// RULE1: data frames always carry at least one byte
// RULE2: payload length is frame bytes minus fill
// RULE3: write data only after transfer-ready or first burst
// RULE4: target bursts limited to nonzero maximum burst size
// RULE5: one write frame serves one transfer-ready only
// RULE6: write fill zero except last frame per grant
// RULE7: read fill zero except final frame of command
// RULE8: no write data after terminating task frame
// RULE9: data offset always a multiple of four
// RULE10: read offsets start zero and run contiguously
// RULE11: write offsets start zero and run contiguously
// RULE12: only the target builds response frames
// RULE13: response payload layout fixed, lengths big-endian
// RULE14: datapres codes none, response, sense, reserved
// RULE15: plain completion uses the no-data code
// RULE16: task frames and transport errors use response code
// RULE17: completion with sense uses the sense code
// RULE18: initiator drops responses with reserved datapres
// RULE19: no-data carries status, both lengths zero
// RULE20: response format: status zero, length four, four bytes
// RULE21: sense format: response length zero, sense 1..1000
// RULE22: fill pads payload to dword, zero to three
package ssf_pkg;
  typedef enum logic [1:0] {
    SSF_DP_NONE = 2'h0,
    SSF_DP_RESP = 2'h1,
    SSF_DP_SENSE = 2'h2,
    SSF_DP_RSVD = 2'h3
  } ssf_dp_t;
  localparam int SSF_RSP_DP_BYTE     = 10;
  localparam int SSF_RSP_STAT_BYTE   = 11;
  localparam int SSF_RSP_SLEN_BYTE   = 16;
  localparam int SSF_RSP_RLEN_BYTE   = 20;
  localparam int SSF_RSP_DATA_BYTE   = 24;
  localparam int SSF_RESP_DATA_LEN   = 4;
  localparam int SSF_SENSE_MAX       = 1000;
  localparam int SSF_RSP_HDR_WORDS   = 6;
  localparam logic [1:0] SSF_RST_FILL = 2'h0;
  localparam logic [31:0] SSF_RST_OFFSET = 32'h0;
  // apb register offsets, initiator side
  localparam logic [7:0] SSF_A_CTRL   = 8'h00; // w: bit0 go, bit1 abort
  localparam logic [7:0] SSF_A_GRANT  = 8'h04; // mapped, writes ignored, reads zero
  localparam logic [7:0] SSF_A_WDATA  = 8'h08; // w: next write word
  localparam logic [7:0] SSF_A_STAT   = 8'h0c; // r: state flags
  localparam logic [7:0] SSF_A_OFFSET = 8'h10; // r: running offset
  localparam logic [7:0] SSF_A_RSP    = 8'h14; // r: last response summary
  localparam logic [7:0] SSF_A_RDATA  = 8'h18; // r: last read word
  localparam logic [7:0] SSF_A_BURST  = 8'h1c; // w: first burst bytes
endpackage : ssf_pkg

// ===== rtl/ssf_target.sv
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ssf_target #(
  parameter int MAX_BURST = 64 // bytes per grant, 0 means no limit
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // link
  ssf_link_if.target       link,
  // user: read data request
  input  wire logic        rdStart,
  input  wire logic [15:0] rdLen,      // bytes, at least one
  input  wire logic [31:0] rdWord,
  // user: completion request
  input  wire logic        cmpStart,
  input  wire logic [1:0]  cmpKind,    // 0 good, 1 sense, 2 error code
  input  wire logic [7:0]  cmpStatus,
  input  wire logic [9:0]  cmpSenseLen,
  input  wire logic [7:0]  cmpRespCode,
  // user: write grant request
  input  wire logic        grStart,
  input  wire logic [15:0] grLen,
  // status
  output logic             busy,
  output logic             wrWordValid,
  output logic [31:0]      wrWord,
  output logic [15:0]      wrBytes
);
  //========================================================================
  // parameter check: the burst limit is a 16-bit byte count of whole dwords
  if (MAX_BURST < 0 || MAX_BURST > 65532 ||
      MAX_BURST % 4 != 0) begin : g_bad_burst
    $error("MAX_BURST must be a multiple of four from 0 to 65532");
  end

  //========================================================================
  // sequencer state and response image
  typedef enum logic [1:0] {
    SSF_T_IDLE = 2'h0, SSF_T_RD = 2'h1, SSF_T_RSP = 2'h3, SSF_T_GR = 2'h2
  } ssf_tst_t;
  ssf_tst_t    state;
  logic [15:0] left;
  logic [31:0] offset;
  logic [3:0]  idx;
  logic [31:0] rspW [0:6];
  logic [2:0]  rspN;
  logic        wrBeat;
  // word positions inside the response image, four bytes per word
  localparam int DP_WORD   = ssf_pkg::SSF_RSP_DP_BYTE / 4;
  localparam int SLEN_WORD = ssf_pkg::SSF_RSP_SLEN_BYTE / 4;
  localparam int RLEN_WORD = ssf_pkg::SSF_RSP_RLEN_BYTE / 4;
  localparam int DATA_WORD = ssf_pkg::SSF_RSP_DATA_BYTE / 4;

  //========================================================================
  // decoders shared by the receive and response paths
  // bytes in one write beat: a whole word unless it closes the frame
  function automatic logic [15:0] beat_bytes(input logic       last,
                                             input logic [1:0] fill);
    beat_bytes = last ? 16'(3'h4 - {1'b0, fill}) : 16'h4;
  endfunction : beat_bytes

  // sense length: the 10-bit request can exceed the largest sense block
  function automatic logic [9:0] sense_len(input logic [9:0] req);
    if (req == 10'h0)
      sense_len = 10'h1;
    else if (req > 10'(ssf_pkg::SSF_SENSE_MAX))
      sense_len = 10'(ssf_pkg::SSF_SENSE_MAX);
    else
      sense_len = req;
  endfunction : sense_len

  //========================================================================
  // write beat decode: command and task frames pass by unseen
  assign wrBeat = link.iValid && link.iKind == 2'h1;

  // write data receive: length from eof minus fill
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrWordValid <= 1'b0;
      wrWord <= 32'h0;
      wrBytes <= 16'h0;
    end else begin
      wrWordValid <= wrBeat;
      if (wrBeat) begin
        wrWord <= link.iData;
        if (link.iSof)
          wrBytes <= beat_bytes(link.iEof, link.iFill); // see RULE2
        else
          wrBytes <= wrBytes + beat_bytes(link.iEof, link.iFill); // see RULE22
      end
    end
  end

  //========================================================================
  // response image builder: fixed header words then payload
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rspN <= 3'h0;
      for (int i = 0; i < 7; i++)
        rspW[i] <= 32'h0;
    end else if (state == SSF_T_IDLE && cmpStart) begin
      for (int i = 0; i < 7; i++)
        rspW[i] <= 32'h0;
      rspN <= 3'(ssf_pkg::SSF_RSP_HDR_WORDS);
      case (cmpKind)
        2'h0: begin // see RULE15
          rspW[DP_WORD] <= {16'h0, 6'h0, ssf_pkg::SSF_DP_NONE,
                            cmpStatus}; // see RULE19
        end
        2'h1: begin // see RULE17
          rspW[DP_WORD] <= {16'h0, 6'h0, ssf_pkg::SSF_DP_SENSE,
                            cmpStatus};
          rspW[SLEN_WORD] <= {22'h0, sense_len(cmpSenseLen)}; // see RULE21
        end
        default: begin // see RULE16
          rspW[DP_WORD] <= {16'h0, 6'h0, ssf_pkg::SSF_DP_RESP,
                            8'h0}; // see RULE20
          rspW[RLEN_WORD] <= 32'(ssf_pkg::SSF_RESP_DATA_LEN); // see RULE13
          rspW[DATA_WORD] <= {24'h0, cmpRespCode};
          rspN <= 3'(ssf_pkg::SSF_RSP_HDR_WORDS + 1);
        end
      endcase
    end
  end

  //========================================================================
  // main sequencer: read data, response, transfer-ready
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= SSF_T_IDLE;
      left <= 16'h0;
      offset <= ssf_pkg::SSF_RST_OFFSET;
      idx <= 4'h0;
      busy <= 1'b0;
      link.tValid <= 1'b0;
      link.tSof <= 1'b0;
      link.tEof <= 1'b0;
      link.tKind <= 2'h0;
      link.tData <= 32'h0;
      link.tOffset <= 32'h0;
      link.tFill <= ssf_pkg::SSF_RST_FILL;
    end else begin
      link.tValid <= 1'b0;
      link.tSof <= 1'b0;
      link.tEof <= 1'b0;
      case (state)
        SSF_T_IDLE: begin
          idx <= 4'h0;
          if (rdStart && rdLen != 16'h0) begin // see RULE1
            state <= SSF_T_RD;
            left <= rdLen;
            offset <= 32'h0; // see RULE10
            busy <= 1'b1;
          end else if (cmpStart) begin // see RULE12
            state <= SSF_T_RSP;
            busy <= 1'b1;
          end else if (grStart && grLen != 16'h0) begin
            state <= SSF_T_GR;
            left <= (MAX_BURST != 0 && grLen > 16'(MAX_BURST)) ?
                    16'(MAX_BURST) : grLen; // see RULE4
            busy <= 1'b1;
          end
        end
        SSF_T_RD: begin
          // one word per frame keeps offsets dword aligned
          link.tValid <= 1'b1;
          link.tSof <= 1'b1;
          link.tEof <= 1'b1;
          link.tKind <= 2'h1;
          link.tData <= rdWord;
          link.tOffset <= offset; // see RULE9
          if (left <= 16'h4) begin
            link.tFill <= 2'(3'h4 - 3'(left)); // see RULE7
            state <= SSF_T_IDLE;
            busy <= 1'b0;
          end else begin
            link.tFill <= 2'h0;
            left <= left - 16'h4;
            offset <= offset + 32'h4; // see RULE10
          end
        end
        SSF_T_RSP: begin
          link.tValid <= 1'b1;
          link.tSof <= idx == 4'h0;
          link.tEof <= idx == 4'(rspN - 3'h1);
          link.tKind <= 2'h3;
          link.tData <= rspW[idx[2:0]];
          link.tOffset <= 32'h0;
          link.tFill <= 2'h0;
          idx <= idx + 4'h1;
          if (idx == 4'(rspN - 3'h1)) begin
            state <= SSF_T_IDLE;
            busy <= 1'b0;
          end
        end
        SSF_T_GR: begin
          // transfer-ready: length word, tOffset always zero
          link.tValid <= 1'b1;
          link.tSof <= 1'b1;
          link.tEof <= 1'b1;
          link.tKind <= 2'h2;
          link.tData <= {16'h0, left};
          link.tOffset <= 32'h0;
          link.tFill <= 2'h0;
          state <= SSF_T_IDLE;
          busy <= 1'b0;
        end
        default: state <= SSF_T_IDLE;
      endcase
    end
  end
endmodule : ssf_target
`default_nettype wire

// ===== sim/ssf_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link checker
module ssf_monitor #(
  parameter int MAX_BURST = 64
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // target to initiator
  input wire logic        tValid,
  input wire logic        tSof,
  input wire logic        tEof,
  input wire logic [1:0]  tKind,
  input wire logic [31:0] tData,
  input wire logic [31:0] tOffset,
  input wire logic [1:0]  tFill,
  // initiator to target
  input wire logic        iValid,
  input wire logic [31:0] iOffset
);
  logic [2:0] rspIdx;
  logic [1:0] rspDp;
  logic       rspBeat;
  logic       rdBeat;
  // beat kinds
  assign rspBeat = tValid && tKind == 2'h3;
  assign rdBeat  = tValid && tKind == 2'h1;
  // word index inside a response; restarts at each end of frame
  always_ff @(posedge clk_sys) begin
    if (srst || (rspBeat && tEof)) rspIdx <= 3'h0;
    else if (rspBeat) rspIdx <= rspIdx + 3'h1;
  end
  // format code held for the later length words
  always_ff @(posedge clk_sys) begin
    if (srst) rspDp <= 2'h0;
    else if (rspBeat && rspIdx == 3'h2) rspDp <= tData[9:8];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  rd_align_a: assert property (tValid |-> tOffset[1:0] == 2'h0)
    else $error("read offset not dword aligned");
  wr_align_a: assert property (iValid |-> iOffset[1:0] == 2'h0)
    else $error("write offset not dword aligned");
  rd_first_a: assert property (
    rdBeat && !$past(rdBeat) |-> tOffset == 32'h0)
    else $error("first read offset not zero");
  rd_run_a: assert property (rdBeat ##1 rdBeat |->
    tOffset == $past(tOffset) + 32'h4 && $past(tFill) == 2'h0)
    else $error("read offsets not contiguous");
  dp_code_a: assert property (
    rspBeat && rspIdx == 3'h2 |-> tData[9:8] != 2'h3)
    else $error("reserved format code sent");
  resp_stat_a: assert property (rspBeat && rspIdx == 3'h2 &&
    tData[9:8] == 2'h1 |-> tData[7:0] == 8'h0)
    else $error("response format status not zero");
  slen_a: assert property (rspBeat && rspIdx == 3'h4 |->
    (rspDp == 2'h2) ? (tData != 0 && tData <= 1000) : tData == 32'h0)
    else $error("sense length wrong");
  rlen_a: assert property (rspBeat && rspIdx == 3'h5 |->
    tData == ((rspDp == 2'h1) ? 32'h4 : 32'h0))
    else $error("response length wrong");
  rsp_end_a: assert property (
    rspBeat && tEof && rspDp == 2'h1 |-> rspIdx == 3'h6)
    else $error("response frame length wrong");
  rsp_start_a: assert property (
    rspBeat && rspIdx == 3'h0 |-> tSof)
    else $error("response start not marked");
  burst_lim_a: assert property (tValid && tKind == 2'h2 |->
    tData[15:0] != 16'h0 && tData[15:0] <= MAX_BURST)
    else $error("grant above burst limit");
endmodule : ssf_monitor
`default_nettype wire

// ===== sim/ssp_data_response_frames_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
// ==========================================================
// both ends joined, user sides driven here
module ssp_data_response_frames_bench;
  logic clk_sys, srst, rdStart, cmpStart, grStart, busy, wrWordValid;
  logic [15:0] rdLen, grLen, wrBytes;
  logic [31:0] rdWord, wrWord, pwdata, prdata, q, w [0:7], off;
  logic [1:0] cmpKind, fl;
  logic [7:0] cmpStatus, cmpRespCode, paddr;
  logic [9:0] cmpSenseLen;
  logic psel, penable, pwrite, pready, pslverr, err;
  bit seen;
  int failures, comparisons, n;
  ssf_link_if link ();
  ssf_target i_ssf_target (.clk_sys(clk_sys), .srst(srst), .link(link),
    .rdStart(rdStart), .rdLen(rdLen), .rdWord(rdWord), .cmpStart(cmpStart),
    .cmpKind(cmpKind), .cmpStatus(cmpStatus), .cmpSenseLen(cmpSenseLen),
    .cmpRespCode(cmpRespCode), .grStart(grStart), .grLen(grLen),
    .busy(busy), .wrWordValid(wrWordValid), .wrWord(wrWord),
    .wrBytes(wrBytes));
  ssf_initiator i_ssf_initiator (.clk_sys(clk_sys), .srst(srst),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ssf_monitor i_ssf_monitor (.clk_sys(clk_sys), .srst(srst),
    .tValid(link.tValid), .tSof(link.tSof), .tEof(link.tEof),
    .tKind(link.tKind), .tData(link.tData), .tOffset(link.tOffset),
    .tFill(link.tFill), .iValid(link.iValid), .iOffset(link.iOffset));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // bounded wait for idle, then a one-cycle start pulse
  task automatic start(input int which);
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_sys);
      if (busy === 1'b0) break;
    end
    if (k == 100) begin failures++; stop_test(); end
    rdStart <= which == 0;
    cmpStart <= which == 1;
    grStart <= which == 2;
    @(posedge clk_sys);
    rdStart <= 1'b0;
    cmpStart <= 1'b0;
    grStart <= 1'b0;
  endtask : start
  // collects one frame; looks one step after each edge
  task automatic get_frame();
    bit done;
    done = 0;
    n = 0;
    for (int i = 0; i < 300 && !done; i++) begin
      #1;
      if (link.tValid === 1'b1) begin
        if (n == 0) begin off = link.tOffset; fl = link.tFill; end
        w[n[2:0]] = link.tData;
        n++;
        done = link.tEof === 1'b1;
      end
      @(posedge clk_sys);
    end
    if (!done) begin failures++; stop_test(); end
  endtask : get_frame
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin failures++; stop_test(); end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // watches the one-cycle write output; a missing word ends the run when must is set
  task automatic wait_wr(input bit must);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = wrWordValid === 1'b1;
    end
    if (must && !seen) begin failures++; stop_test(); end
  endtask : wait_wr
  // response words, then the summary the initiator kept
  task automatic check_rsp(input logic [1:0] dp, input logic [7:0] st,
                           input logic [31:0] sl, input logic [31:0] rl);
    get_frame();
    `CHECK("format", dp, w[2][9:8])
    `CHECK("status", st, w[2][7:0])
    `CHECK("sense len", sl, w[4])
    `CHECK("resp len", rl, w[5])
    apb(1'b0, ssf_pkg::SSF_A_RSP, 32'h0);
    `CHECK("summary", {2'b10, dp, 4'h0, st}, q[15:0])
  endtask : check_rsp
  task automatic scn_read6();
    rdLen <= 16'h6;
    start(0);
    get_frame();
    `CHECK("rd0 off", 32'h0, off)
    `CHECK("rd0 fill", 2'h0, fl)
    get_frame();
    `CHECK("rd1 off", 32'h4, off)
    `CHECK("rd1 fill", 2'h2, fl)
    apb(1'b0, ssf_pkg::SSF_A_RDATA, 32'h0);
    `CHECK("rd word", rdWord, q)
  endtask : scn_read6
  task automatic scn_read1();
    rdLen <= 16'h1;
    start(0);
    get_frame();
    `CHECK("one byte fill", 2'h3, fl)
  endtask : scn_read1
  task automatic scn_cmp();
    cmpKind <= 2'h0; cmpStatus <= 8'h02;
    start(1);
    check_rsp(ssf_pkg::SSF_DP_NONE, 8'h02, 0, 0);
    cmpKind <= 2'h1; cmpSenseLen <= 10'h12;
    start(1);
    check_rsp(ssf_pkg::SSF_DP_SENSE, 8'h02, 32'h12, 0);
    cmpKind <= 2'h2; cmpRespCode <= 8'h09;
    start(1);
    check_rsp(ssf_pkg::SSF_DP_RESP, 8'h0, 0, 32'h4);
    `CHECK("resp code", 8'h09, w[6][7:0])
  endtask : scn_cmp
  task automatic scn_grant();
    grLen <= 16'd100;
    start(2);
    get_frame();
    `CHECK("grant clip", 16'd64, w[0][15:0])
    grLen <= 16'd20;
    start(2);
    get_frame();
    `CHECK("grant", 16'd20, w[0][15:0])
  endtask : scn_grant
  task automatic scn_unmapped();
    apb(1'b0, 8'h40, 32'h0);
    `CHECK("slverr", 1'b1, err)
    `CHECK("unmapped data", 32'h0, q)
  endtask : scn_unmapped
  // write path: abort, command without burst, grant, then first burst
  task automatic scn_write();
    apb(1'b1, ssf_pkg::SSF_A_CTRL, 32'h2);
    apb(1'b1, ssf_pkg::SSF_A_WDATA, 32'h0a0b0c01);
    wait_wr(1'b0);
    `CHECK("held after abort", 1'b0, seen)
    apb(1'b0, ssf_pkg::SSF_A_STAT, 32'h0);
    `CHECK("stat aborted", 32'h6, q)
    apb(1'b1, ssf_pkg::SSF_A_CTRL, 32'h1);
    wait_wr(1'b0);
    `CHECK("held without grant", 1'b0, seen)
    `CHECK("no first burst", 1'b0, link.iFirstBurst)
    grLen <= 16'd6;
    start(2);
    wait_wr(1'b1);
    `CHECK("wr0 word", 32'h0a0b0c01, wrWord)
    `CHECK("wr0 bytes", 16'd4, wrBytes)
    `CHECK("wr0 off", 32'h0, link.iOffset)
    `CHECK("wr0 fill", 2'h0, link.iFill)
    apb(1'b1, ssf_pkg::SSF_A_WDATA, 32'h0a0b0c02);
    wait_wr(1'b1);
    `CHECK("wr1 bytes", 16'd2, wrBytes)
    `CHECK("wr1 off", 32'h4, link.iOffset)
    `CHECK("wr1 fill", 2'h2, link.iFill)
    apb(1'b0, ssf_pkg::SSF_A_OFFSET, 32'h0);
    `CHECK("run offset", 32'h6, q)
    apb(1'b1, ssf_pkg::SSF_A_BURST, 32'h4);
    apb(1'b1, ssf_pkg::SSF_A_CTRL, 32'h1);
    apb(1'b1, ssf_pkg::SSF_A_WDATA, 32'h0a0b0c03);
    wait_wr(1'b1);
    `CHECK("first burst", 1'b1, link.iFirstBurst)
    `CHECK("burst off", 32'h0, link.iOffset)
    `CHECK("burst fill", 2'h0, link.iFill)
    apb(1'b0, ssf_pkg::SSF_A_STAT, 32'h0);
    `CHECK("stat done", 32'h0, q)
  endtask : scn_write
  // reset after the other scenarios: outputs and running state return to rest
  task automatic scn_reset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    `CHECK("busy after reset", 1'b0, busy)
    `CHECK("bytes after reset", 16'h0, wrBytes)
    apb(1'b0, ssf_pkg::SSF_A_OFFSET, 32'h0);
    `CHECK("offset after reset", ssf_pkg::SSF_RST_OFFSET, q)
  endtask : scn_reset
  // main sequence
  initial begin
    {srst, rdStart, cmpStart, grStart, psel, penable, pwrite} = 7'h40;
    {rdLen, grLen, cmpKind, cmpStatus, cmpSenseLen, cmpRespCode} = 0;
    {paddr, pwdata} = 0;
    rdWord = 32'hc0de0006;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    scn_read6();
    scn_read1();
    scn_cmp();
    scn_grant();
    scn_write();
    scn_unmapped();
    scn_reset();
    stop_test();
  end
endmodule : ssp_data_response_frames_bench
`default_nettype wire
